//--- rtl/csdu_pkg.sv
// Purpose: shared constants and types of the chip-select decode unit
// Assumes: 20-bit memory space, 16-bit I/O space, APB register access
// Notes: one word per register, byte addresses below
package csdu_pkg;
	localparam int NUM_CH = 10;
	localparam int GEN_CH = 8;
	localparam int LOWER_CH = 8;
	localparam int BOOT_CH = 9;
	localparam int FIELD_W = 10;
	localparam int WAIT_W = 4;
	localparam int BASE_W = 12;
	localparam int APB_AW = 8;
	localparam int MIN_STATES = 4;

	// register byte offsets
	localparam logic [7:0] CH_BASE_OFF = 8'h00;
	localparam logic [7:0] CH_STRIDE = 8'h08;
	localparam logic [7:0] CH_END_OFF = 8'h50;
	localparam logic [7:0] WIN_OFF = 8'h50;
	localparam logic [7:0] STAT_OFF = 8'h54;
	localparam logic [7:0] LAST_OFF = 8'h58;

	// field positions, start and stop words
	localparam int ADDR_LSB = 6;
	localparam int WAIT_LSB = 0;
	localparam int EN_BIT = 3;
	localparam int IO_BIT = 2;
	localparam int IGN_BIT = 0;
	// window word
	localparam int WIN_IO_BIT = 12;
	// status word
	localparam int ST_BUSY_BIT = 12;
	localparam int ST_WIN_BIT = 13;
	localparam int ST_REF_BIT = 14;
	localparam int ST_RDY_BIT = 15;
	localparam int ST_WAIT_LSB = 16;

	typedef struct packed {
		logic [FIELD_W-1:0] start;
		logic [FIELD_W-1:0] stop;
		logic [WAIT_W-1:0] waits;
		logic en;
		logic io;
		logic ign_rdy;
	} csdu_chan_t;

	typedef struct packed {
		logic start;
		logic [19:0] addr;
		logic io;
		logic refresh;
	} csdu_cyc_t;

	typedef enum logic [2:0] {
		ST_IDLE, ST_T1, ST_T2, ST_T3, ST_TW, ST_T4
	} csdu_state_t;

	// reset values
	localparam csdu_chan_t BOOT_CFG = '{start: 10'h3FF, stop: 10'h3FF,
		waits: 4'hF, en: 1'b1, io: 1'b0, ign_rdy: 1'b0};
	localparam csdu_chan_t OFF_CFG = '{start: 10'h3FF, stop: 10'h000,
		waits: 4'h0, en: 1'b0, io: 1'b0, ign_rdy: 1'b0};
	localparam logic [BASE_W:0] WIN_RESET = 13'h10FF;
endpackage : csdu_pkg

//--- rtl/csdu_region_match.sv
// Purpose: compare one bus address against one programmed region
// Assumes: memory addresses 20 bits, I/O addresses in the low 16 bits
// Notes: purely combinational
`timescale 1ns/100ps
`default_nettype none
module csdu_region_match
	import csdu_pkg::*;
(
	// region setup
	input wire csdu_chan_t cfg,
	// bus cycle
	input wire logic [19:0] addr,
	input wire logic io,
	// result
	output logic hit
);
	logic [FIELD_W-1:0] field;

	// top ten bits: 1K steps in memory, 64-byte steps in I/O
	assign field = io ? addr[15:6] : addr[19:10];
	// start above stop gives an empty range
	assign hit = cfg.en && (cfg.io == io) &&
		(field >= cfg.start) && (field <= cfg.stop);
endmodule : csdu_region_match
`default_nettype wire

//--- rtl/csdu_top.sv
// Purpose: ten programmable selects with wait-state and ready control
// Assumes: one bus cycle request pulse per cycle, APB register access
// Notes: selects are active low and held from T1 through T4
// Notes on behaviour
// - ten separately programmable select outputs
// - each select decodes memory or I/O
// - reset enables only boot select, top 1K
// - start and stop registers per select
// - ten-bit fields against top address bits
// - 1K memory, 64-byte I/O granularity
// - start above stop or disabled never selects
// - per-region wait count and ready use
// - waits done before ready is sampled
// - ignored ready ends cycle after waits
// - all overlapping selects assert together
// - any ready user: fewest waits, then ready
// - all ignore ready: most waits
// - no select inside peripheral register window
// - refresh cycles are decoded too
// - cycle lasts at least four states
// - window relocatable, decode follows it
`timescale 1ns/100ps
`default_nettype none
module csdu_top
	import csdu_pkg::*;
#(
	parameter int CHANNELS = NUM_CH
) (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RESET_N,
	// apb register port
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [APB_AW-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// processor bus cycle
	input wire csdu_cyc_t CYC_REQ,
	input wire logic READY,
	output logic CYCLE_END,
	output logic CYCLE_BUSY,
	output logic WINDOW_ACCESS,
	// select outputs
	output logic UPPER_BOOT_SELECT_N,
	output logic LOWER_REGION_SELECT_N,
	output logic [GEN_CH-1:0] GENERIC_REGION_SELECTS_N
);
	logic rst_meta_q;
	logic rst_n;
	csdu_chan_t cfg_q [CHANNELS];
	logic [BASE_W:0] win_q;
	logic [31:0] prdata_q;
	logic [19:0] last_addr_q;
	logic [CHANNELS-1:0] hit;
	logic [CHANNELS-1:0] sel_d;
	logic [CHANNELS-1:0] sel_q;
	logic win_hit;
	logic win_q_hit;
	logic refresh_q;
	logic use_rdy_d;
	logic use_rdy_q;
	logic [WAIT_W-1:0] waits_d;
	logic [WAIT_W-1:0] waits_q;
	logic [WAIT_W-1:0] cnt_q;
	csdu_state_t state_q;
	csdu_state_t state_d;
	logic accept;
	logic setup;
	logic access;
	logic ch_area;
	logic [3:0] ch_idx;
	logic ch_stop;
	logic mapped;

	// reset release through two flops
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
		end
	end

	// apb decode
	assign setup = PSEL && !PENABLE;
	assign access = PSEL && PENABLE;
	assign ch_area = (PADDR < CH_END_OFF) && (PADDR[1:0] == 2'h0);
	assign ch_idx = 4'((PADDR - CH_BASE_OFF) >> 3);
	assign ch_stop = PADDR[2];

	always_comb begin
		if (ch_area) begin
			mapped = 32'(ch_idx) < CHANNELS;
		end else if (PADDR == WIN_OFF) begin
			mapped = 1'b1;
		end else if (PADDR == STAT_OFF) begin
			mapped = 1'b1;
		end else if (PADDR == LAST_OFF) begin
			mapped = 1'b1;
		end else begin
			mapped = 1'b0;
		end
	end

	assign PREADY = 1'b1;
	assign PSLVERR = access && !mapped;

	// channel registers
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < CHANNELS; i++) begin
				cfg_q[i] <= (i == BOOT_CH) ? BOOT_CFG : OFF_CFG;
			end
		end else if (access && PWRITE && ch_area && mapped) begin
			if (ch_stop) begin
				cfg_q[ch_idx].stop <= PWDATA[ADDR_LSB +: FIELD_W];
				cfg_q[ch_idx].en <= PWDATA[EN_BIT];
				cfg_q[ch_idx].io <= PWDATA[IO_BIT];
				cfg_q[ch_idx].ign_rdy <= PWDATA[IGN_BIT];
			end else begin
				cfg_q[ch_idx].start <= PWDATA[ADDR_LSB +: FIELD_W];
				cfg_q[ch_idx].waits <= PWDATA[WAIT_LSB +: WAIT_W];
			end
		end
	end

	// peripheral window placement
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			win_q <= WIN_RESET;
		end else if (access && PWRITE && PADDR == WIN_OFF) begin
			win_q <= PWDATA[BASE_W:0];
		end
	end

	// read data taken in the setup cycle, shown in the access phase
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			prdata_q <= 32'h00000000;
		end else if (setup && !PWRITE) begin
			prdata_q <= 32'h00000000;
			if (ch_area && mapped) begin
				if (ch_stop) begin
					prdata_q[ADDR_LSB +: FIELD_W] <= cfg_q[ch_idx].stop;
					prdata_q[EN_BIT] <= cfg_q[ch_idx].en;
					prdata_q[IO_BIT] <= cfg_q[ch_idx].io;
					prdata_q[IGN_BIT] <= cfg_q[ch_idx].ign_rdy;
				end else begin
					prdata_q[ADDR_LSB +: FIELD_W] <= cfg_q[ch_idx].start;
					prdata_q[WAIT_LSB +: WAIT_W] <= cfg_q[ch_idx].waits;
				end
			end else if (PADDR == WIN_OFF) begin
				prdata_q[BASE_W:0] <= win_q;
			end else if (PADDR == STAT_OFF) begin
				prdata_q[CHANNELS-1:0] <= sel_q;
				prdata_q[ST_BUSY_BIT] <= CYCLE_BUSY;
				prdata_q[ST_WIN_BIT] <= win_q_hit;
				prdata_q[ST_REF_BIT] <= refresh_q;
				prdata_q[ST_RDY_BIT] <= use_rdy_q;
				prdata_q[ST_WAIT_LSB +: WAIT_W] <= waits_q;
			end else if (PADDR == LAST_OFF) begin
				prdata_q[19:0] <= last_addr_q;
			end
		end
	end

	assign PRDATA = prdata_q;

	// one comparator per select
	for (genvar g = 0; g < CHANNELS; g++) begin : g_match
		csdu_region_match u_match (
			.cfg(cfg_q[g]),
			.addr(CYC_REQ.addr),
			.io(CYC_REQ.io),
			.hit(hit[g])
		);
	end

	// peripheral window: 256-byte block, memory or I/O
	always_comb begin
		if (win_q[WIN_IO_BIT]) begin
			win_hit = CYC_REQ.io && (win_q[BASE_W-1:0] ==
				{4'h0, CYC_REQ.addr[15:8]});
		end else begin
			win_hit = !CYC_REQ.io &&
				(win_q[BASE_W-1:0] == CYC_REQ.addr[19:8]);
		end
	end

	// merge of overlapping regions
	always_comb begin
		logic any_rdy;
		logic [WAIT_W-1:0] min_w;
		logic [WAIT_W-1:0] max_w;
		any_rdy = 1'b0;
		min_w = {WAIT_W{1'b1}};
		max_w = {WAIT_W{1'b0}};
		sel_d = win_hit ? {CHANNELS{1'b0}} : hit;
		for (int i = 0; i < CHANNELS; i++) begin
			if (sel_d[i]) begin
				if (!cfg_q[i].ign_rdy) begin
					any_rdy = 1'b1;
					if (cfg_q[i].waits < min_w) begin
						min_w = cfg_q[i].waits;
					end
				end
				if (cfg_q[i].waits > max_w) begin
					max_w = cfg_q[i].waits;
				end
			end
		end
		if (win_hit) begin
			use_rdy_d = 1'b0;
			waits_d = {WAIT_W{1'b0}};
		end else if (sel_d == {CHANNELS{1'b0}}) begin
			use_rdy_d = 1'b1;
			waits_d = {WAIT_W{1'b0}};
		end else if (any_rdy) begin
			use_rdy_d = 1'b1;
			waits_d = min_w;
		end else begin
			use_rdy_d = 1'b0;
			waits_d = max_w;
		end
	end

	assign accept = CYC_REQ.start && (state_q == ST_IDLE);

	// bus cycle sequencer: T1 T2 T3 [TW...] T4
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (accept) begin
					state_d = ST_T1;
				end
			end
			ST_T1: begin
				state_d = ST_T2;
			end
			ST_T2: begin
				state_d = ST_T3;
			end
			ST_T3, ST_TW: begin
				if (cnt_q != {WAIT_W{1'b0}}) begin
					state_d = ST_TW;
				end else if (use_rdy_q && !READY) begin
					state_d = ST_TW;
				end else begin
					state_d = ST_T4;
				end
			end
			ST_T4: begin
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// wait-state counter, loaded when the cycle is taken
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= {WAIT_W{1'b0}};
		end else if (accept) begin
			cnt_q <= waits_d;
		end else if ((state_q == ST_T3 || state_q == ST_TW) &&
			cnt_q != {WAIT_W{1'b0}}) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	// per-cycle decode results
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			sel_q <= {CHANNELS{1'b0}};
			win_q_hit <= 1'b0;
			refresh_q <= 1'b0;
			use_rdy_q <= 1'b0;
			waits_q <= {WAIT_W{1'b0}};
			last_addr_q <= 20'h00000;
		end else if (accept) begin
			sel_q <= sel_d;
			win_q_hit <= win_hit;
			refresh_q <= CYC_REQ.refresh;
			use_rdy_q <= use_rdy_d;
			waits_q <= waits_d;
			last_addr_q <= CYC_REQ.addr;
		end else if (state_q == ST_T4) begin
			sel_q <= {CHANNELS{1'b0}};
			win_q_hit <= 1'b0;
		end
	end

	// outputs
	assign CYCLE_END = (state_q == ST_T4);
	assign CYCLE_BUSY = (state_q != ST_IDLE);
	assign WINDOW_ACCESS = win_q_hit;
	assign UPPER_BOOT_SELECT_N = !sel_q[BOOT_CH];
	assign LOWER_REGION_SELECT_N = !sel_q[LOWER_CH];
	assign GENERIC_REGION_SELECTS_N = ~sel_q[GEN_CH-1:0];
endmodule : csdu_top
`default_nettype wire

//--- test/csdu_checker.sv
// Purpose: port checks of the select decoder
// Assumes: active-low selects, one bus cycle at a time
// Notes: bound to csdu_top
`timescale 1ns/100ps
`default_nettype none
module csdu_checker
	import csdu_pkg::*;
(
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RESET_N,
	// bus cycle
	input wire csdu_cyc_t CYC_REQ,
	input wire logic CYCLE_END,
	input wire logic CYCLE_BUSY,
	input wire logic WINDOW_ACCESS,
	// selects
	input wire logic UPPER_BOOT_SELECT_N,
	input wire logic LOWER_REGION_SELECT_N,
	input wire logic [GEN_CH-1:0] GENERIC_REGION_SELECTS_N
);
	logic [9:0] sel_n;
	assign sel_n = {UPPER_BOOT_SELECT_N, LOWER_REGION_SELECT_N,
		GENERIC_REGION_SELECTS_N};
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RESET_N);
	sequence s_t1; $rose(CYCLE_BUSY); endsequence
	sequence s_quiet3; !CYCLE_END [*3]; endsequence
	AST_IDLE_NOSEL: assert property (!CYCLE_BUSY |-> &sel_n)
		else $error("select while idle");
	AST_WIN_NOSEL: assert property (WINDOW_ACCESS |-> &sel_n)
		else $error("select in window");
	AST_T1: assert property (CYC_REQ.start && !CYCLE_BUSY |=> CYCLE_BUSY)
		else $error("start not taken");
	AST_MIN4: assert property (s_t1 |-> s_quiet3)
		else $error("cycle too short");
	AST_END_PULSE: assert property (CYCLE_END |=> !CYCLE_END
		&& !CYCLE_BUSY && &sel_n) else $error("bad cycle end");
	AST_SEL_HOLD: assert property (CYCLE_BUSY && $past(CYCLE_BUSY)
		|-> $stable(sel_n)) else $error("selects moved");
	AST_WIN_4: assert property ($rose(WINDOW_ACCESS) |-> ##3 CYCLE_END)
		else $error("window cycle length");
	AST_BUSY_FALL: assert property ($fell(CYCLE_BUSY) |-> $past(CYCLE_END))
		else $error("busy fell early");
endmodule : csdu_checker
bind csdu_top csdu_checker u_chk (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
	.CYC_REQ(CYC_REQ), .CYCLE_END(CYCLE_END), .CYCLE_BUSY(CYCLE_BUSY),
	.WINDOW_ACCESS(WINDOW_ACCESS), .UPPER_BOOT_SELECT_N(UPPER_BOOT_SELECT_N),
	.LOWER_REGION_SELECT_N(LOWER_REGION_SELECT_N),
	.GENERIC_REGION_SELECTS_N(GENERIC_REGION_SELECTS_N));
`default_nettype wire

//--- test/csdu_mem_model.sv
// Purpose: memory behind the selects
// Assumes: answer delay set per cycle by the bench
// Notes: ready toggles while nothing is selected
`timescale 1ns/100ps
`default_nettype none
module csdu_mem_model (
	// clock
	input wire logic clk,
	// selects and delay
	input wire logic [9:0] sel_n,
	input wire logic [2:0] dly,
	// answer
	output logic ready
);
	logic [3:0] cnt_q = 4'h0;
	logic idle_q = 1'b0;
	always_ff @(posedge clk) idle_q <= ~idle_q;
	always_ff @(posedge clk) cnt_q <= &sel_n ? 4'h0 : cnt_q + {3'h0, ~&cnt_q};
	// pins used as plain selects only
	assign ready = &sel_n ? idle_q : cnt_q >= {1'b0, dly};
endmodule : csdu_mem_model
`default_nettype wire

//--- test/test_chip_select_decode_unit.sv
// Purpose: random and corner tests of the select decoder
// Assumes: bench mirrors every register it writes
// Notes: regions sit near the top of each space so they overlap
`timescale 1ns/100ps
`default_nettype none
module test_chip_select_decode_unit
	import csdu_pkg::*;
;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [2:0] dly = 3'h0;
	csdu_cyc_t req = '0;
	logic [31:0] prdata;
	logic pready, pslverr, rdy, c_end, busy, win_acc, boot_n, low_n;
	logic [7:0] gen_n;
	logic [12:0] win_cfg = 13'h10FF;
	csdu_chan_t cfg [10];
	int seed = 32'h8EF82601;
	int fails = 0, tests_run = 0, cyc = 0;
	always #10 clk = ~clk;
	csdu_top dut (.REF_CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(pen),
		.PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .CYC_REQ(req), .READY(rdy),
		.CYCLE_END(c_end), .CYCLE_BUSY(busy), .WINDOW_ACCESS(win_acc),
		.UPPER_BOOT_SELECT_N(boot_n), .LOWER_REGION_SELECT_N(low_n),
		.GENERIC_REGION_SELECTS_N(gen_n));
	csdu_mem_model mem (.clk(clk), .sel_n({boot_n, low_n, gen_n}),
		.dly(dly), .ready(rdy));
	task conclude;
		$display("fails %0d of %0d checks", fails, tests_run);
		if (fails == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			conclude();
		end
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	function automatic logic [31:0] word(input csdu_chan_t c, input logic s);
		return s ? {16'h0, c.stop, 2'b00, c.en, c.io, 1'b0, c.ign_rdy}
			: {16'h0, c.start, 2'b00, c.waits};
	endfunction : word
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task run_cyc(input logic [31:0] x);
		logic [9:0] f, e;
		logic [19:0] a;
		logic io, rf, win, use_r;
		int wu, wi, k, n;
		rf = x[5] & x[6];
		io = x[4] & ~rf;
		f = {6'h3F, x[3:0]};
		a = io ? {4'h0, f, x[12:7]} : {f, x[16:7]};
		win = ({io, a[19:8]} === win_cfg);
		e = '0;
		wu = 99;
		wi = 0;
		use_r = 1'b0;
		for (int i = 0; i < 10; i++)
			if (cfg[i].en && cfg[i].io == io && f >= cfg[i].start
				&& f <= cfg[i].stop && !win) begin
				e[i] = 1'b1;
				use_r |= !cfg[i].ign_rdy;
				if (!cfg[i].ign_rdy && cfg[i].waits < wu) wu = cfg[i].waits;
				if (cfg[i].ign_rdy && cfg[i].waits > wi) wi = cfg[i].waits;
			end
		k = win ? 3 : use_r ? ((2 + wu > x[19:17]) ? 2 + wu : x[19:17]) + 1
			: 3 + wi;
		@(posedge clk);
		req <= '{start: 1'b1, addr: a, io: io, refresh: rf};
		dly <= x[19:17];
		@(posedge clk);
		req.start <= 1'b0;
		#1;
		chk("selects", {22'h0, ~e}, {22'h0, boot_n, low_n, gen_n});
		chk("window hit", {31'h0, win}, {31'h0, win_acc});
		for (n = 0; c_end !== 1'b1 && n < 64; n++) begin
			@(posedge clk);
			#1;
		end
		if (e != 0 || win) chk("cycle length", k, n);
	endtask : run_cyc
	initial begin
		logic [31:0] r, x;
		logic e;
		int ch;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 10; i++) begin
			cfg[i] = (i == 9) ? BOOT_CFG : OFF_CFG;
			for (int s = 0; s < 2; s++) begin
				apb(1'b0, 8'(8 * i + 4 * s), 32'h0, r, e);
				chk("reset word", word(cfg[i], s[0]), r);
			end
		end
		apb(1'b0, 8'h5C, 32'h0, r, e);
		chk("unmapped", 32'h1, {r[30:0], e});
		run_cyc(32'h0000000F);
		run_cyc(32'h0001FF8E);
		apb(1'b0, LAST_OFF, 32'h0, r, e);
		chk("last address", 32'h000FFBFF, r);
		apb(1'b0, STAT_OFF, 32'h0, r, e);
		chk("status idle", 32'h00008000, r);
		for (int t = 0; t < 40; t++) begin
			r = $random(seed);
			ch = r[31:28] % 10;
			cfg[ch] = '{start: {6'h3F, r[3:0]}, stop: {6'h3F, r[7:4]},
				waits: r[11:8], en: r[12] | r[13], io: r[14], ign_rdy: r[15]};
			for (int s = 0; s < 2; s++) begin
				x = word(cfg[ch], s[0]) | (r & 32'hFFFF0030);
				apb(1'b1, 8'(8 * ch + 4 * s), x, x, e);
				apb(1'b0, 8'(8 * ch + 4 * s), 32'h0, x, e);
				chk("reg word", word(cfg[ch], s[0]), x);
			end
			if (r[20] & r[21]) begin
				win_cfg = r[16] ? {5'h10, 6'h3F, r[19:18]}
					: {1'b0, 6'h3F, r[19:14]};
				apb(1'b1, WIN_OFF, {19'h0, win_cfg}, x, e);
			end
			repeat (6) run_cyc($random(seed));
		end
		conclude();
	end
endmodule : test_chip_select_decode_unit
`default_nettype wire
